// file: qtb_pkg.sv
// package for the quad timer block: register map, fields, reset values
// assumes a 32-bit apb slave with one aligned word per register
package qtb_pkg;

  // ----------------------------------------------------------------
  // register map, per timer a window of 0x20 bytes
  // ----------------------------------------------------------------
  localparam logic [11:0] QTB_TIMER_STRIDE = 12'h020;
  localparam logic [4:0]  QTB_OFS_CTRL     = 5'h00;
  localparam logic [4:0]  QTB_OFS_PERIOD_A = 5'h04;
  localparam logic [4:0]  QTB_OFS_PERIOD_B = 5'h08;
  localparam logic [4:0]  QTB_OFS_PRESCALE = 5'h0C;
  localparam logic [4:0]  QTB_OFS_COUNT_A  = 5'h10;
  localparam logic [4:0]  QTB_OFS_COUNT_B  = 5'h14;
  localparam logic [11:0] QTB_OFS_IRQ_STAT = 12'h080;
  localparam logic [11:0] QTB_OFS_IRQ_MASK = 12'h084;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int QTB_CTRL_RUN     = 0;
  localparam int QTB_CTRL_MODE_LO = 1;
  localparam int QTB_CTRL_MODE_HI = 2;
  localparam int QTB_CTRL_PULSE   = 3;
  localparam int QTB_CTRL_PRE4_LO = 4;
  localparam int QTB_CTRL_PRE4_HI = 7;
  localparam int QTB_CTRL_PULSE_WIDTH_FIELD_LO = 8;
  localparam int QTB_CTRL_PULSE_WIDTH_FIELD_HI = 15;

  localparam logic [31:0] QTB_CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] QTB_PERIOD_RESET = 32'hFFFF_FFFF;
  localparam logic [31:0] QTB_ZERO         = 32'h0000_0000;

  // mode codes of the two-bit mode field
  localparam logic [1:0] QTB_MODE_CHAINED   = 2'h0;
  localparam logic [1:0] QTB_MODE_UNCHAINED = 2'h1;
  localparam logic [1:0] QTB_MODE_WATCHDOG  = 2'h2;

  localparam int QTB_NUM_TIMERS = 4;

  typedef enum logic [1:0] {QTB_ST_IDLE, QTB_ST_WAIT, QTB_ST_HIGH} qtb_pulse_state_t;

endpackage : qtb_pkg

// file: qtb_timer_if.sv
// bundle between the top and one timer unit
// assumes the top owns the registers and the unit owns the counters
`timescale 1ns/100ps
interface qtb_timer_if;
  logic [31:0] ctrl;
  logic [31:0] period_a;
  logic [31:0] period_b;
  logic [31:0] prescale;
  logic [31:0] count_a;
  logic [31:0] count_b;
  logic        timeout;
  logic        status_out;

  modport top  (output ctrl, output period_a, output period_b, output prescale,
                input count_a, input count_b, input timeout, input status_out);
  modport unit (input ctrl, input period_a, input period_b, input prescale,
                output count_a, output count_b, output timeout, output status_out);
endinterface : qtb_timer_if

// file: qtb_timer_unit.sv
// one timer: counter a behind a 32-bit prescaler, or split a and b counters, plus status output shaping
// assumes registers arrive through qtb_timer_if and hold while running
`timescale 1ns/100ps
module qtb_timer_unit (
  // clock and reset
  input wire logic    pclk,
  input wire logic    presetn,
  // register side
  qtb_timer_if.unit   tif
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic       run      = tif.ctrl[qtb_pkg::QTB_CTRL_RUN];
  wire logic [1:0] mode     = tif.ctrl[qtb_pkg::QTB_CTRL_MODE_HI:qtb_pkg::QTB_CTRL_MODE_LO];
  wire logic       pulse_md = tif.ctrl[qtb_pkg::QTB_CTRL_PULSE];
  wire logic [3:0] pre4_rl  = tif.ctrl[qtb_pkg::QTB_CTRL_PRE4_HI:qtb_pkg::QTB_CTRL_PRE4_LO];
  wire logic [7:0] pulse_width_field     = tif.ctrl[qtb_pkg::QTB_CTRL_PULSE_WIDTH_FIELD_HI:qtb_pkg::QTB_CTRL_PULSE_WIDTH_FIELD_LO];
  wire logic       split    = (mode == qtb_pkg::QTB_MODE_UNCHAINED);
  wire logic       wdog     = (mode == qtb_pkg::QTB_MODE_WATCHDOG);

  logic [31:0] pre32;
  logic [3:0]  pre4;
  logic [31:0] cnt_a;
  logic [31:0] cnt_b;

  // prescalers count down and fire on zero
  wire logic tick_a = run && ((split && pre4 == 4'h0) || (!split && pre32 == qtb_pkg::QTB_ZERO));
  wire logic tick_b = run && split;
  wire logic tout_a = tick_a && (cnt_a == qtb_pkg::QTB_ZERO);
  wire logic tout_b = tick_b && (cnt_b == qtb_pkg::QTB_ZERO);
  wire logic tout   = tout_a || tout_b;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre32 <= qtb_pkg::QTB_ZERO;
      pre4  <= 4'h0;
      cnt_a <= qtb_pkg::QTB_ZERO;
      cnt_b <= qtb_pkg::QTB_ZERO;
    end else if (!run) begin
      // stopped timer preloads so the first period is full length
      pre32 <= tif.prescale;
      pre4  <= pre4_rl;
      cnt_a <= tif.period_a;
      cnt_b <= tif.period_b;
    end else begin
      if (split) begin
        pre4 <= (pre4 == 4'h0) ? pre4_rl : pre4 - 4'h1;
      end else begin
        pre32 <= (pre32 == qtb_pkg::QTB_ZERO) ? tif.prescale : pre32 - 32'h0000_0001;
      end
      if (tick_a) begin
        cnt_a <= tout_a ? tif.period_a : cnt_a - 32'h0000_0001;
      end
      if (tick_b) begin
        cnt_b <= tout_b ? tif.period_b : cnt_b - 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // status output
  // ----------------------------------------------------------------
  qtb_pkg::qtb_pulse_state_t pstate;
  logic [7:0]                pcnt;
  logic                      stat;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstate <= qtb_pkg::QTB_ST_IDLE;
      pcnt   <= 8'h00;
      stat   <= 1'b0;
    end else if (wdog) begin
      pstate <= qtb_pkg::QTB_ST_IDLE;
      stat   <= 1'b0;
    end else if (!pulse_md) begin
      pstate <= qtb_pkg::QTB_ST_IDLE;
      if (tout) begin
        stat <= ~stat;
      end
    end else begin
      unique case (pstate)
        qtb_pkg::QTB_ST_IDLE: begin
          stat <= 1'b0;
          if (tout && pulse_width_field != 8'h00) begin
            pstate <= qtb_pkg::QTB_ST_WAIT;
          end
        end
        qtb_pkg::QTB_ST_WAIT: begin
          stat   <= 1'b1;
          pcnt   <= pulse_width_field - 8'h01;
          pstate <= (pulse_width_field == 8'h01) ? qtb_pkg::QTB_ST_IDLE : qtb_pkg::QTB_ST_HIGH;
        end
        qtb_pkg::QTB_ST_HIGH: begin
          // time-outs during the pulse are absorbed, not queued
          // pcnt holds the cycles still to go after the first high one
          if (pcnt == 8'h00) begin
            stat   <= 1'b0;
            pstate <= qtb_pkg::QTB_ST_IDLE;
          end
          pcnt <= pcnt - 8'h01;
        end
      endcase
    end
  end

  assign tif.count_a    = cnt_a;
  assign tif.count_b    = cnt_b;
  assign tif.timeout    = tout;
  assign tif.status_out = stat;

endmodule : qtb_timer_unit

// file: qtb_top.sv
// quad timer block top: apb register file, four timer units, interrupts
// assumes apb driven synchronously to pclk; registers are zero wait state
`timescale 1ns/100ps
module qtb_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // timer status outputs
  output logic      [3:0]  timeout_status_output,
  // interrupt lines
  output logic             sys_interrupt_line_4,
  output logic             sys_interrupt_line_22,
  output logic             sys_interrupt_line_11,
  output logic             irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  localparam int N = qtb_pkg::QTB_NUM_TIMERS;

  qtb_timer_if tif [N] ();

  logic [31:0] ctrl     [N];
  logic [31:0] period_a [N];
  logic [31:0] period_b [N];
  logic [31:0] prescale [N];
  logic [N-1:0] irq_stat;
  logic [N-1:0] irq_mask;
  logic [N-1:0] tout_vec;
  logic [N-1:0] stat_vec;
  logic [31:0]  cnt_a_vec [N];
  logic [31:0]  cnt_b_vec [N];

  wire logic       wr_en   = psel && penable && pwrite;
  wire logic [2:0] sel_idx = paddr[7:5];
  wire logic [4:0] sel_ofs = paddr[4:0];
  wire logic       in_tmr  = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0);
  wire logic       is_stat = (paddr == qtb_pkg::QTB_OFS_IRQ_STAT);
  wire logic       is_mask = (paddr == qtb_pkg::QTB_OFS_IRQ_MASK);
  wire logic       ofs_ok  = (sel_ofs <= qtb_pkg::QTB_OFS_COUNT_B);
  wire logic       hit     = (in_tmr && ofs_ok) || is_stat || is_mask;

  // ----------------------------------------------------------------
  // timer instances
  // ----------------------------------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_tmr
    assign tif[g].ctrl     = ctrl[g];
    assign tif[g].period_a = period_a[g];
    assign tif[g].period_b = period_b[g];
    assign tif[g].prescale = prescale[g];
    assign tout_vec[g]     = tif[g].timeout;
    assign stat_vec[g]     = tif[g].status_out;
    assign cnt_a_vec[g]    = tif[g].count_a;
    assign cnt_b_vec[g]    = tif[g].count_b;

    qtb_timer_unit u_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .tif     (tif[g])
    );

    wire logic sel_me = wr_en && in_tmr && (sel_idx == 3'(g));

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctrl[g]     <= qtb_pkg::QTB_CTRL_RESET;
        period_a[g] <= qtb_pkg::QTB_PERIOD_RESET;
        period_b[g] <= qtb_pkg::QTB_PERIOD_RESET;
        prescale[g] <= qtb_pkg::QTB_ZERO;
      end else if (sel_me) begin
        // mode is taken live; software changes it only while stopped
        if (sel_ofs == qtb_pkg::QTB_OFS_CTRL)     ctrl[g]     <= pwdata;
        if (sel_ofs == qtb_pkg::QTB_OFS_PERIOD_A) period_a[g] <= pwdata;
        if (sel_ofs == qtb_pkg::QTB_OFS_PERIOD_B) period_b[g] <= pwdata;
        if (sel_ofs == qtb_pkg::QTB_OFS_PRESCALE) prescale[g] <= pwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  wire logic [N-1:0] clr_bits = (wr_en && is_stat) ? pwdata[N-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      // a time-out in the clearing cycle wins over the clear
      irq_stat <= (irq_stat & ~clr_bits) | tout_vec;
      if (wr_en && is_mask) irq_mask <= pwdata[N-1:0];
    end
  end

  assign sys_interrupt_line_4  = irq_stat[0] & irq_mask[0];
  assign sys_interrupt_line_22 = irq_stat[1] & irq_mask[1];
  assign sys_interrupt_line_11 = irq_stat[2] & irq_mask[2];
  assign irq                   = |(irq_stat & irq_mask);
  assign timeout_status_output = stat_vec;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  function automatic logic [31:0] qtb_pick(input logic [31:0] v [N], input logic [2:0] i);
    logic [31:0] r;
    r = qtb_pkg::QTB_ZERO;
    for (int k = 0; k < N; k++) begin
      if (i == 3'(k)) r = v[k];
    end
    return r;
  endfunction : qtb_pick

  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = qtb_pkg::QTB_ZERO;
    if (is_stat) begin
      next_prdata = {28'h000_0000, irq_stat};
    end else if (is_mask) begin
      next_prdata = {28'h000_0000, irq_mask};
    end else if (in_tmr) begin
      unique case (sel_ofs)
        qtb_pkg::QTB_OFS_CTRL:     next_prdata = qtb_pick(ctrl, sel_idx);
        qtb_pkg::QTB_OFS_PERIOD_A: next_prdata = qtb_pick(period_a, sel_idx);
        qtb_pkg::QTB_OFS_PERIOD_B: next_prdata = qtb_pick(period_b, sel_idx);
        qtb_pkg::QTB_OFS_PRESCALE: next_prdata = qtb_pick(prescale, sel_idx);
        qtb_pkg::QTB_OFS_COUNT_A:  next_prdata = qtb_pick(cnt_a_vec, sel_idx);
        qtb_pkg::QTB_OFS_COUNT_B:  next_prdata = qtb_pick(cnt_b_vec, sel_idx);
        default:                   next_prdata = qtb_pkg::QTB_ZERO;
      endcase
    end
  end

  // read data registered in the setup cycle, so access is zero wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= qtb_pkg::QTB_ZERO;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

endmodule : qtb_top

// file: qtb_top_props.sv
// checker for qtb_top: apb decode, status shaping, interrupt routing
// assumes it is bound to qtb_top and sees only its ports
`timescale 1ns/100ps
module qtb_top_props (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // status and interrupts
  input wire logic [3:0]  timeout_status_output,
  input wire logic        sys_interrupt_line_4,
  input wire logic        sys_interrupt_line_22,
  input wire logic        sys_interrupt_line_11,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // snooped control words: the bench never changes mode mid-pulse
  // ----------------------------------------------------------------
  logic [31:0] ctl [4];
  logic [7:0]  hi_cnt;
  wire [3:0]   ts     = timeout_status_output;
  wire         acc    = psel && penable;
  wire         treg   = (paddr[11:7] == 5'h00) && (paddr[4:0] <= 5'h14);
  wire         mapped = (paddr[1:0] == 2'h0) && (treg || paddr == 12'h080 || paddr == 12'h084);
  wire         ctl_wr = acc && pwrite && treg && (paddr[4:0] == 5'h00);
  wire         pulse1 = ctl[1][3] && (ctl[1][2:1] != 2'h2);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl <= '{default: 32'h0000_0000};
    else if (ctl_wr) ctl[paddr[6:5]] <= pwdata;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_cnt <= 8'h00;
    else hi_cnt <= ts[1] ? hi_cnt + 8'h01 : 8'h00;
  end
  sequence bad_acc_s;
    acc && !mapped;
  endsequence
  sequence pulse_done_s;
    pulse1 && $fell(ts[1]);
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  ready_always_a: assert property (pready)
    else $error("pready low");
  slverr_decode_a: assert property (pslverr == (acc && !mapped))
    else $error("pslverr does not match decode");
  err_rdata_a: assert property (bad_acc_s ##0 !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  line_needs_irq_a: assert property (sys_interrupt_line_4 || sys_interrupt_line_22
    || sys_interrupt_line_11 |-> irq) else $error("line high without irq");
  pulse_short_a: assert property (pulse1 && ts[1] |-> hi_cnt < ctl[1][15:8])
    else $error("pulse longer than width");
  pulse_end_a: assert property (pulse_done_s |-> hi_cnt == ctl[1][15:8])
    else $error("pulse width wrong");
  for (genvar t = 0; t < 4; t++) begin : g_wd
    wd_status_off_a: assert property (ctl[t][2:1] == 2'h2 ##1 ctl[t][2:1] == 2'h2
      |-> !ts[t]) else $error("status active in watchdog mode");
  end
  stopped_quiet_a: assert property (ctl[0][3:0] == 4'h0 ##1 ctl[0][3:0] == 4'h0
    |-> $stable(ts[0])) else $error("status moved while stopped");
endmodule : qtb_top_props
bind qtb_top qtb_top_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .timeout_status_output, .sys_interrupt_line_4,
  .sys_interrupt_line_22, .sys_interrupt_line_11, .irq);

// file: qtb_top_tb.sv
// self-checking bench for qtb_top: register rows, then timer scenarios
// assumes the checker binds itself from its own file
`timescale 1ns/100ps
module qtb_top_tb;
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} qtb_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, l4, l22, l11, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  tso;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          n;
  qtb_row_t    rows [8] = '{
    '{12'h004, 1'b0, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0},
    '{12'h028, 1'b0, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0},
    '{12'h060, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{12'h06C, 1'b1, 32'h0000_1234, 32'h0000_0000, 1'b0},
    '{12'h06C, 1'b0, 32'h0000_0000, 32'h0000_1234, 1'b0},
    '{12'h0FC, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1},
    '{12'h002, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1},
    '{12'h0F0, 1'b1, 32'h0000_5555, 32'h0000_0000, 1'b1}};
  qtb_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timeout_status_output(tso), .sys_interrupt_line_4(l4),
    .sys_interrupt_line_22(l22), .sys_interrupt_line_11(l11), .irq);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // hang guard: the whole run needs well under 3000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      fail_count++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // mode is set with run low, then run is raised
  task automatic cfg(input int t, input logic [31:0] c, pa, pb, ps);
    apb(1'b1, 12'(t * 32 + 4), pa);
    apb(1'b1, 12'(t * 32 + 8), pb);
    apb(1'b1, 12'(t * 32 + 12), ps);
    apb(1'b1, 12'(t * 32), c);
    apb(1'b1, 12'(t * 32), c | 32'h0000_0001);
  endtask : cfg
  task automatic gap(input int i, output int k);
    logic p;
    p = tso[i];
    k = 0;
    while (tso[i] === p && k < 400) begin
      @(posedge pclk);
      k++;
    end
  endtask : gap
  task automatic tally_and_finish();
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(32'(err), 32'(rows[i].e));
      if (!rows[i].w) chk(rd, rows[i].x);
    end
    cfg(0, 32'h0000_0000, 32'h0000_0003, 32'h0000_0003, 32'h0000_0001);
    gap(0, n);
    gap(0, n);
    chk(n, 8);
    gap(0, n);
    chk(n, 8);
    apb(1'b1, 12'h000, 32'h0000_0000);
    cfg(0, 32'h0000_0032, 32'h0000_0001, 32'hFFFF_FFFF, 32'h0000_0000);
    gap(0, n);
    gap(0, n);
    chk(n, 8);
    apb(1'b1, 12'h000, 32'h0000_0000);
    cfg(0, 32'h0000_0032, 32'hFFFF_FFFF, 32'h0000_0004, 32'h0000_0000);
    gap(0, n);
    gap(0, n);
    chk(n, 5);
    apb(1'b1, 12'h000, 32'h0000_0000);
    cfg(1, 32'h0000_0308, 32'h0000_0009, 32'h0000_0009, 32'h0000_0000);
    gap(1, n);
    gap(1, n);
    chk(n, 3);
    gap(1, n);
    chk(n, 7);
    gap(1, n);
    chk(n, 3);
    apb(1'b1, 12'h020, 32'h0000_0000);
    apb(1'b1, 12'h080, 32'h0000_000F);
    for (int t = 0; t < 4; t++) begin
      cfg(t, (t == 2) ? 32'h0000_0004 : 32'h0000_0000, 32'h0000_0002, 32'h0000_0002,
          32'h0000_0000);
      repeat (12) begin
        @(negedge pclk);
        if (t == 2) chk(32'(tso[2]), 32'h0000_0000);
      end
      apb(1'b1, 12'(t * 32), 32'h0000_0000);
      @(negedge pclk);
      chk(32'({l4, l22, l11, irq}), 32'h0000_0000);
      apb(1'b0, 12'h080, 32'h0000_0000);
      chk(rd, 32'h0000_0001 << t);
      apb(1'b1, 12'h084, 32'h0000_0001 << t);
      @(negedge pclk);
      chk(32'({l4, l22, l11, irq}), 32'({t == 0, t == 1, t == 2, 1'b1}));
      apb(1'b1, 12'h080, 32'h0000_0001 << t);
      apb(1'b0, 12'h080, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
      apb(1'b1, 12'h084, 32'h0000_0000);
    end
    // mid-run reset with timer 0 running and its interrupt unmasked
    cfg(0, 32'h0000_0000, 32'h0000_0001, 32'h0000_0001, 32'h0000_0000);
    apb(1'b1, 12'h084, 32'h0000_000F);
    repeat (5) @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk(32'({tso, l4, l22, l11, irq}), 32'h0000_0000);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, 32'hFFFF_FFFF);
    apb(1'b0, 12'h084, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h080, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : qtb_top_tb
